// [hw/hfo_ctrl.sv]
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module hfo_ctrl
  import hfo_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic      [HFO_FREQ_W-1:0] hfint_freq_code_o,
  output logic      [HFO_TRIM_W-1:0] hfint_trim_code_o,
  output logic      [HFO_NEXT_OSC_SOURCE_W-1:0] next_osc_source_o,
  output logic      [HFO_MHZ_W-1:0]  freq_mhz_o,
  output logic                       freq_reserved_o
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_hit;
  logic [HFO_FREQ_W-1:0] freq_r;
  logic [HFO_TRIM_W-1:0] trim_r;
  logic [HFO_NEXT_OSC_SOURCE_W-1:0] next_osc_source_r;
  logic [HFO_MHZ_W-1:0]  mhz;
  logic                  rsv;
  logic [31:0]           rd_nxt;
  logic [31:0]           prdata_r;
  logic [HFO_MHZ_W-1:0]  mhz_r;
  logic                  rsv_r;

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready_o = 1'b1;
  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_en    = psel_i & ~penable_i & ~pwrite_i;

  always_comb begin
    addr_hit = 1'b1;
    rd_nxt   = 32'h0000_0000;
    unique case (paddr_i)
      HFO_FREQ_SELECT_ADDR: rd_nxt[HFO_FREQ_W-1:0] = freq_r;
      HFO_TUNE_ADDR:        rd_nxt[HFO_TRIM_W-1:0] = trim_r;
      HFO_NEXT_OSC_ADDR:    rd_nxt[HFO_NEXT_OSC_SOURCE_LSB +: HFO_NEXT_OSC_SOURCE_W] = next_osc_source_r;
      HFO_STATUS_ADDR:      rd_nxt[HFO_MHZ_W:0] = {rsv, mhz};
      default:              addr_hit = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      freq_r <= HFO_FREQ_RST;
    end else if (wr_en && paddr_i == HFO_FREQ_SELECT_ADDR) begin
      freq_r <= pwdata_i[HFO_FREQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trim_r <= HFO_TRIM_RST;
    end else if (wr_en && paddr_i == HFO_TUNE_ADDR) begin
      trim_r <= pwdata_i[HFO_TRIM_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      next_osc_source_r <= HFO_NEXT_OSC_SOURCE_RST;
    end else if (wr_en && paddr_i == HFO_NEXT_OSC_ADDR) begin
      next_osc_source_r <= pwdata_i[HFO_NEXT_OSC_SOURCE_LSB +: HFO_NEXT_OSC_SOURCE_W];
    end
  end

  // Read data is captured in setup so it is stable through the access phase.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_r <= rd_nxt;
    end
  end

  // ****************************************************************
  // Frequency selection
  // ****************************************************************
  hfo_freq_decode u_decode (
    .hfint_freq_code_i (freq_r),
    .next_osc_source_i (next_osc_source_r),
    .freq_mhz_o        (mhz),
    .freq_reserved_o   (rsv)
  );

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mhz_r <= 6'h00;
      rsv_r <= 1'b0;
    end else begin
      mhz_r <= mhz;
      rsv_r <= rsv;
    end
  end

  assign prdata_o          = prdata_r;
  assign hfint_freq_code_o = freq_r;
  assign hfint_trim_code_o = trim_r;
  assign next_osc_source_o = next_osc_source_r;
  assign freq_mhz_o        = mhz_r;
  assign freq_reserved_o   = rsv_r;

endmodule : hfo_ctrl

// [hw/hfo_freq_decode.sv]
`timescale 1ns/10ps
module hfo_freq_decode
  import hfo_pkg::*;
(
  input  wire logic [HFO_FREQ_W-1:0] hfint_freq_code_i,
  input  wire logic [HFO_NEXT_OSC_SOURCE_W-1:0] next_osc_source_i,
  output logic      [HFO_MHZ_W-1:0]  freq_mhz_o,
  output logic                       freq_reserved_o
);

  always_comb begin
    freq_mhz_o      = 6'h00;
    freq_reserved_o = 1'b1;
    if (next_osc_source_i == HFO_NEXT_OSC_SOURCE_PLL) begin
      unique case (hfint_freq_code_i)
        HFO_CODE_8M:  begin freq_mhz_o = 6'h10; freq_reserved_o = 1'b0; end
        HFO_CODE_12M: begin freq_mhz_o = 6'h18; freq_reserved_o = 1'b0; end
        HFO_CODE_16M: begin freq_mhz_o = 6'h20; freq_reserved_o = 1'b0; end
        default:      freq_reserved_o = 1'b1;
      endcase
    end else if (next_osc_source_i == HFO_NEXT_OSC_SOURCE_HFINT) begin
      freq_reserved_o = 1'b0;
      if (hfint_freq_code_i[HFO_FREQ_W-1]) begin
        freq_mhz_o = 6'h20;
      end else begin
        unique case (hfint_freq_code_i)
          HFO_CODE_1M:  freq_mhz_o = 6'h01;
          HFO_CODE_2M:  freq_mhz_o = 6'h02;
          HFO_CODE_4M:  freq_mhz_o = 6'h04;
          HFO_CODE_8M:  freq_mhz_o = 6'h08;
          HFO_CODE_12M: freq_mhz_o = 6'h0c;
          HFO_CODE_16M: freq_mhz_o = 6'h10;
          HFO_CODE_32M: freq_mhz_o = 6'h20;
          default:      freq_reserved_o = 1'b1;
        endcase
      end
    end
  end

endmodule : hfo_freq_decode

// [hw/hfo_pkg.sv]
package hfo_pkg;

  // ****************************************************************
  // Register map (word aligned, byte addresses)
  // ****************************************************************
  localparam logic [11:0] HFO_FREQ_SELECT_ADDR = 12'h000;
  localparam logic [11:0] HFO_TUNE_ADDR        = 12'h004;
  localparam logic [11:0] HFO_NEXT_OSC_ADDR    = 12'h008;
  localparam logic [11:0] HFO_STATUS_ADDR      = 12'h00c;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          HFO_FREQ_W      = 4;
  localparam int          HFO_TRIM_W      = 6;
  localparam int          HFO_NEXT_OSC_SOURCE_W      = 3;
  localparam int          HFO_NEXT_OSC_SOURCE_LSB    = 4;
  localparam int          HFO_MHZ_W       = 6;
  localparam logic [3:0]  HFO_FREQ_RST    = 4'h6;
  localparam logic [5:0]  HFO_TRIM_RST    = 6'h00;
  localparam logic [2:0]  HFO_NEXT_OSC_SOURCE_RST    = 3'h6;

  // ****************************************************************
  // Next oscillator source codes
  // ****************************************************************
  localparam logic [2:0]  HFO_NEXT_OSC_SOURCE_PLL    = 3'h0;
  localparam logic [2:0]  HFO_NEXT_OSC_SOURCE_HFINT  = 3'h6;

  // ****************************************************************
  // Frequency codes
  // ****************************************************************
  localparam logic [3:0]  HFO_CODE_1M     = 4'h0;
  localparam logic [3:0]  HFO_CODE_2M     = 4'h1;
  localparam logic [3:0]  HFO_CODE_RSV    = 4'h2;
  localparam logic [3:0]  HFO_CODE_4M     = 4'h3;
  localparam logic [3:0]  HFO_CODE_8M     = 4'h4;
  localparam logic [3:0]  HFO_CODE_12M    = 4'h5;
  localparam logic [3:0]  HFO_CODE_16M    = 4'h6;
  localparam logic [3:0]  HFO_CODE_32M    = 4'h7;

endpackage : hfo_pkg

// [verif/hfo_ctrl_properties.sv]
`timescale 1ns/10ps
module hfo_ctrl_props
  import hfo_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [11:0]           paddr_i,
  input wire logic [31:0]           pwdata_i,
  input wire logic [31:0]           prdata_o,
  input wire logic [HFO_FREQ_W-1:0] hfint_freq_code_o,
  input wire logic [HFO_NEXT_OSC_SOURCE_W-1:0] next_osc_source_o,
  input wire logic [HFO_MHZ_W-1:0]  freq_mhz_o,
  input wire logic                  freq_reserved_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_top; next_osc_source_o == 3'h6 && hfint_freq_code_o[3] |=> freq_mhz_o == 6'h20;
  endproperty
  a_top: assert property (p_top) else $error("top codes not 32");
  property p_rsv; next_osc_source_o == 3'h6 && hfint_freq_code_o == 4'h2 |=> freq_reserved_o;
  endproperty
  a_rsv: assert property (p_rsv) else $error("code 2 not reserved");
  property p_pll; next_osc_source_o == 3'h0 && hfint_freq_code_o == 4'h5 |=> freq_mhz_o == 6'h18;
  endproperty
  a_pll: assert property (p_pll) else $error("pll 24 wrong");
  property p_fs; psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000 |=> prdata_o[31:4] == '0;
  endproperty
  a_fs: assert property (p_fs) else $error("freq upper bits set");
  property p_wr; psel_i && penable_i && pwrite_i && paddr_i == 12'h000
    |=> hfint_freq_code_o == $past(pwdata_i[3:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("freq write lost");
  property p_tn; psel_i && !penable_i && !pwrite_i && paddr_i == 12'h004 |=> prdata_o[31:6] == '0;
  endproperty
  a_tn: assert property (p_tn) else $error("tune upper bits set");
endmodule : hfo_ctrl_props
bind hfo_ctrl hfo_ctrl_props hfo_ctrl_props_inst (.*);

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, pready_o, pslverr_o, freq_reserved_o, er;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0]  hfint_freq_code_o;
  logic [5:0]  hfint_trim_code_o, freq_mhz_o;
  logic [2:0]  next_osc_source_o;
  int          fail_count = 0, comparisons = 0;
  // ********
  // Rows: source, code, reserved flag at bit 7, MHz.
  // ********
  logic [14:0] rows [15] = '{15'h6001, 15'h6102, 15'h6280, 15'h6304, 15'h6408,
    15'h650c, 15'h6610, 15'h6720, 15'h6820, 15'h6f20, 15'h0410, 15'h0518,
    15'h0620, 15'h0780, 15'h0280};
  hfo_ctrl hfo_ctrl_inst (.*);
  always #50 ref_clk_i = ~ref_clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read data and error are taken at the completing edge, before our own release lands.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1) @(posedge ref_clk_i);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask : xfer
  task give_verdict;
    $display("Checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h10);
    // Upper bits of the frequency-select write are all ones so a leaking field shows on readback.
    for (int i = 0; i < 15; i++) begin
      xfer(1'b1, 12'h008, {25'h0, rows[i][14:12], 4'h0});
      xfer(1'b1, 12'h000, {28'hfffffff, rows[i][11:8]});
      xfer(1'b0, 12'h000, 32'h0);
      chk(rd, {28'h0, rows[i][11:8]});
      xfer(1'b0, 12'h00c, 32'h0);
      chk(rd, {25'h0, rows[i][7], rows[i][5:0]});
      chk({26'h0, freq_mhz_o}, {26'h0, rows[i][5:0]});
      chk({31'h0, freq_reserved_o}, {31'h0, rows[i][7]});
      chk({28'h0, hfint_freq_code_o}, {28'h0, rows[i][11:8]});
      chk({29'h0, next_osc_source_o}, {29'h0, rows[i][14:12]});
    end
    xfer(1'b1, 12'h004, 32'hffffffff);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h3f);
    chk({26'h0, hfint_trim_code_o}, 32'h3f);
    xfer(1'b1, 12'h010, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    xfer(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h6);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    chk({26'h0, hfint_trim_code_o}, 32'h0);
    chk({29'h0, next_osc_source_o}, 32'h6);
    give_verdict();
  end
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
endmodule : tb
